/* File: psr_pkg.sv */
package psr_pkg;

    // -----------------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------------
    localparam int unsigned FILTER_CYCLES      = 3;
    localparam int unsigned WAKE_DELAY_DEFAULT = 64;

    // -----------------------------------------------------------------------
    // Register map (word index on the plain port)
    // -----------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ    = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;
    localparam logic [3:0] ADDR_USER   = 4'h4;
    localparam logic [3:0] ADDR_CAL    = 4'h5;

    // Control field positions.
    localparam int unsigned CTRL_IDLE_BIT  = 0;
    localparam int unsigned CTRL_RESET_BIT = 1;
    localparam int unsigned CTRL_CAL_BIT   = 2;

    // Interrupt event positions.
    localparam int unsigned EV_RESET = 0;
    localparam int unsigned EV_STATE = 1;
    localparam int unsigned EV_SUPPLY = 2;
    localparam int unsigned EV_WIDTH  = 3;

    // Reset values.
    localparam logic [2:0]  CTRL_RESET_VAL = 3'h0;
    localparam logic [15:0] USER_RESET_VAL = 16'h0000;
    localparam logic [2:0]  MASK_RESET_VAL = 3'h0;

    typedef enum logic [1:0] {
        PSR_SLEEP,
        PSR_IDLE,
        PSR_LIMP,
        PSR_ACTIVE
    } psr_state_e;

endpackage : psr_pkg

/* File: psr_power_state_reset_control.sv */
// How it works
// [R1] State changes only after all inputs hold steady for three cycles.
// [R2] Power-up is recognised only once the main supply passed start-up level.
// [R3] Power-up enters sleep, drives outputs off, resets all registers.
// [R4] Sleep to active waits a parameter wake-up delay before switching.
// [R5] Idle stops switching; registers and serial port work with logic supply.
// [R6] Limp entry resets registers; afterwards reads work and writes are ignored.
// [R7] Limp regulation runs only while main and external driver supplies good.
// [R8] Active switching follows the dimming input high, stops when low.
// [R9] Each high-side driver starts only after its bootstrap level is good.
// [R10] Every reset source sets the transmission error flag.
// [R11] Enable pin low disables serial port, resets registers, enters sleep.
// [R12] Enable pin low also turns off driver regulator and stops switching.
// [R13] Logic supply low blocks drivers and serial access, resets registers.
// [R14] Driver supply low stops drivers and switching, keeps registers.
// [R15] Writing the software reset bit restores every writable register except the interrupt status.
// [R16] Calibration survives software reset, readable only when enabled.
// [R17] Software idle bit moves active to idle; clearing returns to active.
// [R18] Filtered limp-home input enters limp; low releases normal selection.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module psr_power_state_reset_control #(
    parameter int unsigned WAKE_DELAY = psr_pkg::WAKE_DELAY_DEFAULT
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Supply comparators and pins, asynchronous.
    input  wire logic        main_supply_level,
    input  wire logic        enable_uv_pin,
    input  wire logic        driver_regulator_level,
    input  wire logic        external_driver_supply_level,
    input  wire logic        logic_supply_level,
    input  wire logic        backup_mode_input,
    input  wire logic        dimming_input,
    input  wire logic [1:0]  bootstrap_level,
    // Calibration result from the trim engine, same clock.
    input  wire logic [15:0] cal_result,
    // Register port.
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    // Power stage controls.
    output logic             switchEnable,
    output logic      [1:0]  high_side_drivers,
    output logic             lowSideEnable,
    output logic             regulatorEnable,
    output logic             serialEnable,
    output logic             serialReadOnly,
    output logic             transmission_error_flag,
    output logic      [1:0]  powerState,
    output logic             irq
);
    import psr_pkg::*;

    // -----------------------------------------------------------------------
    // Input synchronisers and stability filter
    // -----------------------------------------------------------------------
    localparam int unsigned NIN = 9;
    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] syncA_ff;
    logic [NIN-1:0] syncB_ff;
    logic [NIN-1:0] lastIn_ff;
    logic [NIN-1:0] filt_ff;
    logic [1:0]     stableCnt_ff;
    logic           idleBitFilt_ff;
    logic           idleLast_ff;

    assign rawIn = {bootstrap_level, dimming_input, backup_mode_input,
                    logic_supply_level, external_driver_supply_level,
                    driver_regulator_level, enable_uv_pin,
                    main_supply_level};

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end
        else
        begin
            syncA_ff <= rawIn;
            syncB_ff <= syncA_ff;
        end
    end

    logic [2:0] ctrl_ff;

    // All state inputs, including the software idle bit, must hold for the
    // filter interval before the filtered copy is updated.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lastIn_ff      <= '0;
            idleLast_ff    <= 1'b0;
            stableCnt_ff   <= 2'h0;
            filt_ff        <= '0;
            idleBitFilt_ff <= 1'b0;
        end
        else
        begin
            lastIn_ff   <= syncB_ff;
            idleLast_ff <= ctrl_ff[CTRL_IDLE_BIT];
            if (syncB_ff != lastIn_ff || ctrl_ff[CTRL_IDLE_BIT] != idleLast_ff)
                stableCnt_ff <= 2'h0;
            else if (stableCnt_ff != 2'(FILTER_CYCLES - 1))
                stableCnt_ff <= stableCnt_ff + 2'h1;
            else
            begin
                filt_ff        <= lastIn_ff; // [R1]
                idleBitFilt_ff <= idleLast_ff; // [R1]
            end
        end
    end

    logic       fMain;
    logic       fEnable;
    logic       fDrvReg;
    logic       fExtDrv;
    logic       fLogic;
    logic       fLimp;
    logic       fDim;
    logic [1:0] fBoot;
    assign fMain   = filt_ff[0];
    assign fEnable = filt_ff[1];
    assign fDrvReg = filt_ff[2];
    assign fExtDrv = filt_ff[3];
    assign fLogic  = filt_ff[4];
    assign fLimp   = filt_ff[5];
    assign fDim    = filt_ff[6];
    assign fBoot   = filt_ff[8:7];

    // -----------------------------------------------------------------------
    // Power state machine
    // -----------------------------------------------------------------------
    psr_state_e state_ff;
    psr_state_e nxt_state;
    logic       poweredUp_ff;
    logic [15:0] wakeCnt_ff;
    logic       wakeDone;

    assign wakeDone = (wakeCnt_ff == 16'(WAKE_DELAY));

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            poweredUp_ff <= 1'b0;
        else if (fMain)
            poweredUp_ff <= 1'b1; // [R2]
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            PSR_SLEEP:
            begin
                if (poweredUp_ff && fEnable)
                    nxt_state = fLimp ? PSR_LIMP : PSR_ACTIVE;
            end
            PSR_IDLE:
            begin
                if (fLimp)
                    nxt_state = PSR_LIMP; // [R18]
                else if (!idleBitFilt_ff)
                    nxt_state = PSR_ACTIVE; // [R17]
            end
            PSR_LIMP:
            begin
                if (!fLimp)
                    nxt_state = PSR_ACTIVE; // [R18]
            end
            PSR_ACTIVE:
            begin
                if (fLimp)
                    nxt_state = PSR_LIMP; // [R18]
                else if (idleBitFilt_ff && fMain && fLogic)
                    nxt_state = PSR_IDLE; // [R17]
            end
        endcase
        if (!fEnable)
            nxt_state = PSR_SLEEP; // [R11]
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_ff <= PSR_SLEEP; // [R3]
        else
            state_ff <= nxt_state;
    end

    // Wake-up delay restarts on every entry from sleep.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            wakeCnt_ff <= 16'h0000;
        else if (state_ff == PSR_SLEEP)
            wakeCnt_ff <= 16'h0000;
        else if (!wakeDone)
            wakeCnt_ff <= wakeCnt_ff + 16'h0001; // [R4]
    end

    // -----------------------------------------------------------------------
    // Reset sources
    // -----------------------------------------------------------------------
    logic limpEntry;
    logic swReset;
    logic hwRegReset;
    logic serialOk;
    logic wrAllowed;

    assign limpEntry  = (nxt_state == PSR_LIMP) && (state_ff != PSR_LIMP);
    assign swReset    = regWr && wrAllowed && (regAddr == ADDR_CTRL)
                        && regWrData[CTRL_RESET_BIT];
    assign hwRegReset = !fEnable || !fLogic || limpEntry; // [R6] [R11] [R13]
    assign serialOk   = fEnable && fLogic && poweredUp_ff; // [R11] [R13]
    assign wrAllowed  = serialOk && (state_ff != PSR_LIMP); // [R6]

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    logic [15:0] user_ff;
    logic [2:0]  irqStat_ff;
    logic [2:0]  mask_ff;
    logic        ter_ff;
    logic [2:0]  events;
    logic        stateChg;
    logic        supplyFault;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= CTRL_RESET_VAL; // [R3]
            user_ff <= USER_RESET_VAL;
            mask_ff <= MASK_RESET_VAL;
        end
        else if (hwRegReset || swReset)
        begin
            ctrl_ff <= CTRL_RESET_VAL; // [R15]
            user_ff <= USER_RESET_VAL; // [R15]
            mask_ff <= MASK_RESET_VAL;
        end
        else if (regWr && wrAllowed)
        begin
            // Driver supply faults touch no register contents except the supply bit of the interrupt status.
            if (regAddr == ADDR_CTRL)
                ctrl_ff <= {regWrData[CTRL_CAL_BIT], 1'b0,
                            regWrData[CTRL_IDLE_BIT]}; // [R15]
            if (regAddr == ADDR_USER)
                user_ff <= regWrData;
            if (regAddr == ADDR_MASK)
                mask_ff <= regWrData[EV_WIDTH-1:0];
        end
    end

    // The flag stays set until software clears it by writing a one.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ter_ff <= 1'b1; // [R10]
        else if (hwRegReset || swReset)
            ter_ff <= 1'b1; // [R10]
        else if (regWr && wrAllowed && regAddr == ADDR_STATUS && regWrData[0])
            ter_ff <= 1'b0;
    end

    assign stateChg    = (nxt_state != state_ff);
    assign supplyFault = !fDrvReg || !fExtDrv;
    always_comb
    begin
        events           = '0;
        events[EV_RESET] = hwRegReset || swReset;
        events[EV_STATE] = stateChg;
        events[EV_SUPPLY] = supplyFault;
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irqStat_ff <= '0;
        else if (regWr && wrAllowed && regAddr == ADDR_IRQ)
            irqStat_ff <= (irqStat_ff & ~regWrData[EV_WIDTH-1:0]) | events;
        else
            irqStat_ff <= irqStat_ff | events;
    end

    assign irq = |(irqStat_ff & mask_ff);

    // Read data appears the cycle after the strobe.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            regRdData <= 16'h0000;
        else if (regRd && serialOk)
        begin
            unique case (regAddr)
                ADDR_CTRL:   regRdData <= {13'h0000, ctrl_ff};
                ADDR_STATUS: regRdData <= {13'h0000, powerState, ter_ff};
                ADDR_IRQ:    regRdData <= {13'h0000, irqStat_ff};
                ADDR_MASK:   regRdData <= {13'h0000, mask_ff};
                ADDR_USER:   regRdData <= user_ff;
                ADDR_CAL:    regRdData <= ctrl_ff[CTRL_CAL_BIT] ?
                                          cal_result : 16'h0000; // [R16]
                default:     regRdData <= 16'h0000;
            endcase
        end
        else
            regRdData <= 16'h0000;
    end

    // -----------------------------------------------------------------------
    // Power stage outputs
    // -----------------------------------------------------------------------
    logic runOk;
    logic nxtSwitch;

    always_comb
    begin
        runOk = 1'b0;
        unique case (state_ff)
            PSR_SLEEP:  runOk = 1'b0; // [R3] [R12]
            PSR_IDLE:   runOk = 1'b0; // [R5]
            PSR_LIMP:   runOk = fMain && fExtDrv; // [R7]
            PSR_ACTIVE: runOk = wakeDone && fDim; // [R4] [R8]
        endcase
        nxtSwitch = runOk && fDrvReg && fExtDrv && fLogic; // [R13] [R14]
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            switchEnable      <= 1'b0;
            lowSideEnable     <= 1'b0;
            high_side_drivers <= 2'h0;
            regulatorEnable   <= 1'b0;
        end
        else
        begin
            switchEnable      <= nxtSwitch;
            lowSideEnable     <= nxtSwitch; // [R14]
            high_side_drivers <= {2{nxtSwitch}} & fBoot; // [R9]
            regulatorEnable   <= fEnable && poweredUp_ff; // [R12]
        end
    end

    assign serialEnable            = serialOk;
    assign serialReadOnly          = (state_ff == PSR_LIMP); // [R6]
    assign transmission_error_flag = ter_ff;
    assign powerState              = state_ff;

endmodule : psr_power_state_reset_control

/* File: psr_chk.sv */
`timescale 1ns/100ps
module psr_chk (
    // Clock, reset and far-side levels.
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        enable_uv_pin,
    input wire logic        driver_regulator_level,
    input wire logic        external_driver_supply_level,
    input wire logic        logic_supply_level,
    input wire logic        dimming_input,
    input wire logic [1:0]  bootstrap_level,
    // Design outputs.
    input wire logic        switchEnable,
    input wire logic [1:0]  high_side_drivers,
    input wire logic        lowSideEnable,
    input wire logic        regulatorEnable,
    input wire logic        serialEnable,
    input wire logic        serialReadOnly,
    input wire logic        transmission_error_flag,
    input wire logic [1:0]  powerState
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_sleep_quiet: assert property (
        powerState == 2'h0 && $past(powerState) == 2'h0 |-> !switchEnable
        && high_side_drivers == 2'h0) else $error("drive in sleep");
    a_idle_quiet: assert property (
        powerState == 2'h1 && $past(powerState) == 2'h1 |-> !switchEnable
        && high_side_drivers == 2'h0) else $error("drive in idle");
    a_dim_gate: assert property (
        (powerState == 2'h3 && !dimming_input) [*8] |-> !switchEnable)
        else $error("switching with dimming low");
    a_boot_gate: assert property (
        (!bootstrap_level[0]) [*8] |-> !high_side_drivers[0])
        else $error("high side on without bootstrap");
    a_enable_off: assert property (
        (!enable_uv_pin) [*8] |-> ##2 powerState == 2'h0 && !serialEnable
        && !regulatorEnable && !switchEnable) else $error("enable low");
    a_logic_off: assert property (
        (!logic_supply_level) [*8] |-> ##2 !serialEnable && !lowSideEnable
        && high_side_drivers == 2'h0) else $error("logic supply low");
    a_drive_off: assert property (
        (!driver_regulator_level || !external_driver_supply_level) [*8]
        |-> ##2 !switchEnable && !lowSideEnable) else $error("driver low");
    a_limp_ro: assert property (
        powerState == 2'h2 |-> serialReadOnly) else $error("limp writable");
    a_limp_flag: assert property (
        $rose(powerState == 2'h2) |-> ##[0:2] transmission_error_flag)
        else $error("flag not set on limp entry");
endmodule : psr_chk

bind psr_power_state_reset_control psr_chk chk (.*);

/* File: psr_supply_model.sv */
`timescale 1ns/100ps
module psr_supply_model #(
    parameter logic [15:0] CAL_VALUE = 16'h5a3c
) (
    // Clock and commanded levels.
    input  wire logic        sys_clk,
    input  wire logic [8:0]  lvlCmd,
    // Comparator, pin and trim outputs.
    output logic             main_supply_level,
    output logic             enable_uv_pin,
    output logic             driver_regulator_level,
    output logic             external_driver_supply_level,
    output logic             logic_supply_level,
    output logic             backup_mode_input,
    output logic             dimming_input,
    output logic      [1:0]  bootstrap_level,
    output logic      [15:0] cal_result
);
    logic [8:0] lvl_ff = 9'h000;

    // Bootstrap caps charge from the external driver supply only.
    always @(posedge sys_clk)
        lvl_ff <= {lvlCmd[8:2], lvlCmd[1:0] & {2{lvlCmd[5]}}};

    assign {main_supply_level, enable_uv_pin, driver_regulator_level,
            external_driver_supply_level, logic_supply_level,
            backup_mode_input, dimming_input, bootstrap_level} = lvl_ff;
    assign cal_result = CAL_VALUE;
endmodule : psr_supply_model

/* File: psr_power_state_reset_control_bench.sv */
`timescale 1ns/100ps
module psr_power_state_reset_control_bench;
    import psr_pkg::*;
    localparam logic [15:0] CALV = 16'h5a3c;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [8:0]  lvlCmd = 9'h0f7;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    int          failCount = 0;
    int          nTests = 0;
    int          cyc = 0;
    wire logic main_supply_level, enable_uv_pin, driver_regulator_level;
    wire logic external_driver_supply_level, logic_supply_level, irq;
    wire logic backup_mode_input, dimming_input, lowSideEnable;
    wire logic switchEnable, regulatorEnable, serialEnable, serialReadOnly;
    wire logic transmission_error_flag;
    wire logic [1:0]  bootstrap_level, high_side_drivers, powerState;
    wire logic [15:0] cal_result, regRdData;

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    psr_supply_model #(.CAL_VALUE(CALV)) far (.*);
    psr_power_state_reset_control #(.WAKE_DELAY(4)) dut (.*);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        nTests++;
        if (g !== e)
        begin
            failCount++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt

    task automatic lv(input logic [8:0] v);
        @(posedge sys_clk);
        lvlCmd <= v;
    endtask : lv

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        cmp(regRdData, e);
    endtask : rd

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failCount++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        wt(20);
        cmp({14'h0, powerState}, 16'h0000);
        lv(9'h1f7);
        wt(11);
        cmp({13'h0, powerState, switchEnable}, 16'h0006);
        wt(20);
        cmp({13'h0, powerState, switchEnable}, 16'h0007);
        cmp({14'h0, high_side_drivers}, 16'h0003);
        wr(ADDR_IRQ, 16'h0007);
        rd(ADDR_CTRL, 16'h0000);
        rd(ADDR_STATUS, 16'h0007);
        rd(ADDR_USER, 16'h0000);
        rd(ADDR_MASK, 16'h0000);
        rd(4'hf, 16'h0000);
        $display("test power-up ended");
        // A two-cycle dip on the enable pin must be filtered out.
        wr(ADDR_USER, 16'h1234);
        lv(9'h177);
        wt(1);
        lv(9'h1f7);
        wt(20);
        cmp({14'h0, powerState}, 16'h0003);
        rd(ADDR_USER, 16'h1234);
        lv(9'h1f3);
        wt(20);
        cmp({15'h0, switchEnable}, 16'h0000);
        lv(9'h1f6);
        wt(20);
        cmp({13'h0, high_side_drivers, switchEnable}, 16'h0005);
        lv(9'h1b7);
        wt(20);
        cmp({14'h0, switchEnable, lowSideEnable}, 16'h0000);
        rd(ADDR_USER, 16'h1234);
        cmp({15'h0, irq}, 16'h0000);
        wr(ADDR_MASK, 16'h0007);
        wt(1);
        cmp({15'h0, irq}, 16'h0001);
        lv(9'h1f7);
        wt(20);
        wr(ADDR_IRQ, 16'h0007);
        wt(1);
        cmp({15'h0, irq}, 16'h0000);
        rd(ADDR_IRQ, 16'h0000);
        $display("test power stage ended");
        wr(ADDR_CTRL, 16'h0004);
        rd(ADDR_CAL, CALV);
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_CAL, 16'h0000);
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0006);
        wr(ADDR_USER, 16'hbeef);
        wr(ADDR_MASK, 16'h0005);
        wr(ADDR_CTRL, 16'h0002);
        wt(4);
        rd(ADDR_USER, 16'h0000);
        rd(ADDR_MASK, 16'h0000);
        rd(ADDR_CTRL, 16'h0000);
        rd(ADDR_STATUS, 16'h0007);
        wr(ADDR_CTRL, 16'h0004);
        rd(ADDR_CAL, CALV);
        wr(ADDR_CTRL, 16'h0001);
        wt(20);
        cmp({13'h0, powerState, switchEnable}, 16'h0002);
        wr(ADDR_USER, 16'h0a0a);
        rd(ADDR_USER, 16'h0a0a);
        wr(ADDR_CTRL, 16'h0000);
        wt(20);
        cmp({14'h0, powerState}, 16'h0003);
        $display("test software control ended");
        wr(ADDR_STATUS, 16'h0001);
        lv(9'h1ff);
        wt(20);
        cmp({13'h0, powerState, serialReadOnly}, 16'h0005);
        rd(ADDR_USER, 16'h0000);
        wr(ADDR_USER, 16'h5555);
        rd(ADDR_USER, 16'h0000);
        rd(ADDR_STATUS, 16'h0005);
        lv(9'h1df);
        wt(20);
        cmp({15'h0, switchEnable}, 16'h0000);
        lv(9'h1f7);
        wt(30);
        cmp({14'h0, powerState}, 16'h0003);
        $display("test backup mode ended");
        wr(ADDR_USER, 16'h0d0d);
        lv(9'h177);
        wt(20);
        cmp({13'h0, powerState, serialEnable}, 16'h0000);
        cmp({15'h0, regulatorEnable}, 16'h0000);
        cmp({15'h0, switchEnable}, 16'h0000);
        rd(ADDR_USER, 16'h0000);
        lv(9'h1f7);
        wt(30);
        cmp({14'h0, powerState}, 16'h0003);
        rd(ADDR_USER, 16'h0000);
        wr(ADDR_USER, 16'h0c0c);
        lv(9'h1e7);
        wt(20);
        cmp({13'h0, serialEnable, high_side_drivers}, 16'h0000);
        lv(9'h1f7);
        wt(20);
        rd(ADDR_USER, 16'h0000);
        $display("test undervoltage ended");
        tally_and_finish();
    end
endmodule : psr_power_state_reset_control_bench
